// ==== dpot_host.sv ====
module dpot_host (
    // Clock and two-wire bus
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl = 1'b1,
    output logic      o_sda = 1'b1
);
    timeunit 1ns;
    timeprecision 100ps;
    task automatic q(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    // 200 ns bit: four cycles low, four high; the device answers three cycles after SCL falls
    task automatic bitx(input logic d, output logic r);
        q(2);
        o_sda = d;
        q(2);
        o_scl = 1'b1;
        q(4);
        r = i_sda;
        o_scl = 1'b0;
    endtask
    task automatic start;
        o_sda = 1'b0;
        q(4);
        o_scl = 1'b0;
    endtask
    task automatic stop;
        q(3);
        o_sda = 1'b0;
        q(3);
        o_scl = 1'b1;
        q(4);
        o_sda = 1'b1;
        q(4);
    endtask
    // Ack slot: e is what the host leaves on SDA, a is the level seen there
    task automatic xbyte(input logic [7:0] d, input logic e, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
        bitx(e, a);
    endtask
endmodule

// ==== dpot_i2c_slave.sv ====
`include "dpot_map.svh"
// Operation
// - Address is fixed five bits plus two select pins; eighth bit is direction.
// - Matching address gets ACK on ninth clock; others stay idle until the next start or stop.
// - Start is SDA falling while SCL high; device detects it.
// - In writes the byte after the address is the instruction byte.
// - Instruction MSB one selects quick commands, zero selects register access.
// - Register mode: third bit picks store or wiper; low five bits address.
// - Command mode: four bits after MSB are the command; eleven defined.
// - Command mode: low three bits select channel, only 001 and 011 valid.
// - After the instruction ACK one data byte carries the value.
// - Each byte is eight bits MSB first plus one acknowledge bit.
// - SDA changes only while SCL low, except start and stop.
// - Current read sends the pointed wiper, then the next after each ACK.
// - Stop is SDA rising while SCL high; device returns to idle.
// - Wipers reload from the store at power-up and on restore, about 300 us.
// - A save keeps the store busy for about 26 ms.
// - Power-up sets wipers to midscale, then restores; blank store holds midscale.
// - Code 1 restores one channel, 2 saves one, 7 restores all.
// - Codes 5/6 decrement one/all, 10/11 increment one/all by one step.
// - Codes 3/4 halve one/all, 8/9 double one/all by shifting.
// - Nine doublings from zero and eight halvings from full scale reach the ends.
// - While the store is busy the address is not acknowledged.
// - Register mode with store select addresses the store, tolerance bytes included.
module dpot_i2c_slave
    import dpot_pkg::*;
#(
    parameter int unsigned P_SAVE_CYC    = `DPOT_SAVE_CYC,
    parameter int unsigned P_RESTORE_CYC = `DPOT_RESTORE_CYC
) (
    // Clock, reset, enable
    input  logic       i_mclk,
    input  logic       i_rstn,
    input  logic       i_ce,
    // Two-wire bus pins
    input  logic       i_scl,
    input  logic       i_sda,
    output logic       o_sda,
    output logic       o_sda_oe_n,
    // Address straps
    input  logic       i_address_select_pin_high,
    input  logic       i_address_select_pin_low,
    // Wiper settings and status
    output logic [7:0] o_first_wiper_channel,
    output logic [7:0] o_second_wiper_channel,
    output logic       o_busy
);
    logic [2:0]      scl_sq, sda_sq;
    logic [1:0]      ash_q, asl_q;
    logic            scl_rise, scl_fall, start, stop, sda_s;
    logic [6:0]      own_addr;
    dpot_state_t     st_q, st_d;
    logic [3:0]      cnt_q, cnt_d;
    logic [7:0]      sh_q, sh_d, instr_q, instr_d, rd_byte, nv_rd;
    logic [4:0]      ptr_q, ptr_d, ptr_next;
    logic            rw_q, rw_d, ee_q, ee_d, oe_n_q, oe_n_d, mack_q, mack_d;
    logic            go_q, go_d, wwr_q, wwr_d, sda_o_q, busy, busy_q;
    dpot_nv_wr_t     nvwr_q, nvwr_d;
    logic [1:0]      rs_q, rs_d, rdone, ch_mask;
    logic [1:0][7:0] w_q, w_d, nv_wiper;
    logic [3:0]      cmd;
    logic            all_cmd;

    // Pins are asynchronous: two flops, then a third stage only for edge finding
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            scl_sq  <= 3'h7;
            sda_sq  <= 3'h7;
            ash_q   <= 2'h0;
            asl_q   <= 2'h0;
            sda_o_q <= 1'b0;
            busy_q  <= 1'b1;
        end else if (i_ce) begin
            scl_sq  <= {scl_sq[1:0], i_scl};
            sda_sq  <= {sda_sq[1:0], i_sda};
            ash_q   <= {ash_q[0], i_address_select_pin_high};
            asl_q   <= {asl_q[0], i_address_select_pin_low};
            sda_o_q <= 1'b0;
            busy_q  <= busy;
        end
    end

    assign sda_s    = sda_sq[1];
    assign scl_rise = scl_sq[1] & ~scl_sq[2];
    assign scl_fall = ~scl_sq[1] & scl_sq[2];
    assign start    = scl_sq[1] & scl_sq[2] & ~sda_sq[1] & sda_sq[2];
    assign stop     = scl_sq[1] & scl_sq[2] & sda_sq[1] & ~sda_sq[2];
    assign own_addr = {`DPOT_ADDR_FIXED, ash_q[1], asl_q[1]};

    assign cmd     = instr_q[`DPOT_CMD_HI:`DPOT_CMD_LO];
    assign all_cmd = cmd == `DPOT_C_HALVE_ALL || cmd == `DPOT_C_DEC_ALL ||
                     cmd == `DPOT_C_DBL_ALL || cmd == `DPOT_C_INC_ALL;
    assign ch_mask = (instr_q[2:0] == `DPOT_CH_FIRST)  ? 2'h1 :
                     (instr_q[2:0] == `DPOT_CH_SECOND) ? 2'h2 : 2'h0;

    // Read source: wiper pair, or the store when store select was given
    always_comb begin
        if (ee_q) begin
            rd_byte = nv_rd;
        end else if (ptr_q == `DPOT_LOC_FIRST) begin
            rd_byte = w_q[0];
        end else if (ptr_q == `DPOT_LOC_SECOND) begin
            rd_byte = w_q[1];
        end else begin
            rd_byte = 8'h00;
        end
    end
    assign ptr_next = ee_q ? ptr_q + 5'h01 : ptr_q ^ 5'h02;

    always_comb begin
        st_d    = st_q;
        cnt_d   = cnt_q;
        sh_d    = sh_q;
        rw_d    = rw_q;
        instr_d = instr_q;
        ptr_d   = ptr_q;
        ee_d    = ee_q;
        oe_n_d  = oe_n_q;
        mack_d  = mack_q;
        go_d    = 1'b0;
        wwr_d   = 1'b0;
        nvwr_d  = '0;
        rs_d    = 2'h0;
        if (stop) begin
            st_d   = ST_IDLE;
            oe_n_d = 1'b1;
        end else if (start) begin
            st_d   = ST_ADDR;
            cnt_d  = 4'h0;
            oe_n_d = 1'b1;
        end else if (scl_rise) begin
            unique case (st_q)
                ST_ADDR, ST_INSTR, ST_DATA: begin
                    sh_d  = {sh_q[6:0], sda_s};
                    cnt_d = cnt_q + 4'h1;
                end
                ST_RD:   cnt_d = cnt_q + 4'h1;
                ST_MACK: mack_d = ~sda_s;
                default: ;
            endcase
        end else if (scl_fall) begin
            // Every SDA move but the release on start or stop happens here, just after SCL has gone low
            unique case (st_q)
                ST_ADDR: if (cnt_q == 4'h8) begin
                    if (sh_q[7:1] == own_addr && !busy) begin
                        st_d   = ST_AACK;
                        oe_n_d = 1'b0;
                        rw_d   = sh_q[0];
                    end else begin
                        st_d = ST_SKIP;
                    end
                end
                ST_AACK: begin
                    cnt_d  = 4'h0;
                    oe_n_d = 1'b1;
                    st_d   = ST_INSTR;
                    if (rw_q) begin
                        st_d   = ST_RD;
                        oe_n_d = rd_byte[7];
                        sh_d   = {rd_byte[6:0], 1'b0};
                        ptr_d  = ptr_next;
                    end
                end
                ST_INSTR: if (cnt_q == 4'h8) begin
                    st_d    = ST_IACK;
                    oe_n_d  = 1'b0;
                    instr_d = sh_q;
                end
                ST_IACK: begin
                    cnt_d  = 4'h0;
                    oe_n_d = 1'b1;
                    st_d   = ST_DATA;
                    if (instr_q[`DPOT_MODE_BIT]) begin
                        go_d = 1'b1;
                        if (cmd == `DPOT_C_RESTORE) begin
                            rs_d = ch_mask;
                        end else if (cmd == `DPOT_C_RESET) begin
                            rs_d = 2'h3;
                        end else if (cmd == `DPOT_C_SAVE && ch_mask != 2'h0) begin
                            nvwr_d = '{en: 1'b1, addr: {2'h0, instr_q[2:0]},
                                       data: ch_mask[1] ? w_q[1] : w_q[0]};
                        end
                    end else begin
                        ptr_d = instr_q[4:0];
                        ee_d  = instr_q[`DPOT_EE_BIT];
                    end
                end
                ST_DATA: if (cnt_q == 4'h8) begin
                    st_d   = ST_DACK;
                    oe_n_d = 1'b0;
                    // Quick commands may carry a third byte; it is taken and dropped
                    if (!instr_q[`DPOT_MODE_BIT]) begin
                        if (instr_q[`DPOT_EE_BIT]) begin
                            nvwr_d = '{en: 1'b1, addr: instr_q[4:0], data: sh_q};
                        end else begin
                            wwr_d = 1'b1;
                        end
                    end
                end
                ST_DACK: begin
                    oe_n_d = 1'b1;
                    st_d   = ST_SKIP;
                end
                ST_RD: begin
                    if (cnt_q == 4'h8) begin
                        oe_n_d = 1'b1;
                        st_d   = ST_MACK;
                    end else begin
                        oe_n_d = sh_q[7];
                        sh_d   = {sh_q[6:0], 1'b0};
                    end
                end
                ST_MACK: begin
                    cnt_d = 4'h0;
                    st_d  = ST_SKIP;
                    if (mack_q) begin
                        st_d   = ST_RD;
                        oe_n_d = rd_byte[7];
                        sh_d   = {rd_byte[6:0], 1'b0};
                        ptr_d  = ptr_next;
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 8'h00;
            rw_q    <= 1'b0;
            instr_q <= 8'h00;
            ptr_q   <= `DPOT_LOC_FIRST;
            ee_q    <= 1'b0;
            oe_n_q  <= 1'b1;
            mack_q  <= 1'b0;
            go_q    <= 1'b0;
            wwr_q   <= 1'b0;
            nvwr_q  <= '0;
            rs_q    <= 2'h0;
        end else if (i_ce) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            sh_q    <= sh_d;
            rw_q    <= rw_d;
            instr_q <= instr_d;
            ptr_q   <= ptr_d;
            ee_q    <= ee_d;
            oe_n_q  <= oe_n_d;
            mack_q  <= mack_d;
            go_q    <= go_d;
            wwr_q   <= wwr_d;
            nvwr_q  <= nvwr_d;
            rs_q    <= rs_d;
        end
    end

    dpot_nvstore #(
        .P_SAVE_CYC    (P_SAVE_CYC),
        .P_RESTORE_CYC (P_RESTORE_CYC)
    ) u_store (
        .i_mclk         (i_mclk),
        .i_rstn         (i_rstn),
        .i_ce           (i_ce),
        .i_wr           (nvwr_q),
        .i_restore      (rs_q),
        .i_rd_loc       (ptr_q),
        .o_rd_data      (nv_rd),
        .o_nv_wiper     (nv_wiper),
        .o_busy         (busy),
        .o_restore_done (rdone)
    );

    // Saturating arithmetic keeps the wiper inside the ladder
    for (genvar g = 0; g < 2; g++) begin : g_wiper
        localparam logic [4:0] LOC = (g == 0) ? `DPOT_LOC_FIRST : `DPOT_LOC_SECOND;
        always_comb begin
            w_d[g] = w_q[g];
            if (rdone[g]) begin
                w_d[g] = nv_wiper[g];
            end else if (wwr_q && instr_q[4:0] == LOC) begin
                w_d[g] = sh_q;
            // A bad channel code voids even the all-channel commands
            end else if (go_q && (all_cmd ? ch_mask != 2'h0 : ch_mask[g])) begin
                case (cmd)
                    `DPOT_C_HALVE_ONE, `DPOT_C_HALVE_ALL: w_d[g] = w_q[g] >> 1;
                    `DPOT_C_DEC_ONE, `DPOT_C_DEC_ALL:
                        w_d[g] = (w_q[g] == 8'h00) ? 8'h00 : w_q[g] - 8'h01;
                    `DPOT_C_DBL_ONE, `DPOT_C_DBL_ALL:
                        w_d[g] = (w_q[g] == 8'h00) ? 8'h01 :
                                 (w_q[g][7] ? `DPOT_FULL : {w_q[g][6:0], 1'b0});
                    `DPOT_C_INC_ONE, `DPOT_C_INC_ALL:
                        w_d[g] = (w_q[g] == `DPOT_FULL) ? `DPOT_FULL : w_q[g] + 8'h01;
                    default: ;
                endcase
            end
        end
        always_ff @(posedge i_mclk) begin
            if (!i_rstn) begin
                w_q[g] <= `DPOT_MID;
            end else if (i_ce) begin
                w_q[g] <= w_d[g];
            end
        end
    end

    assign o_sda                  = sda_o_q;
    assign o_sda_oe_n             = oe_n_q;
    assign o_first_wiper_channel  = w_q[0];
    assign o_second_wiper_channel = w_q[1];
    assign o_busy                 = busy_q;

    default clocking dck @(posedge i_mclk); endclocking
    default disable iff (!i_rstn || !i_ce);

    sequence s_addr_end;
        st_q == ST_ADDR && scl_fall && cnt_q == 4'h8 && !start && !stop;
    endsequence

    start_detect_a: assert property (start |=> st_q == ST_ADDR && cnt_q == 4'h0)
        else $error("start not detected");
    stop_idle_a: assert property (stop |=> st_q == ST_IDLE && oe_n_q)
        else $error("stop did not return to idle");
    addr_ack_a: assert property (s_addr_end and (sh_q[7:1] == own_addr && !busy)
        |=> st_q == ST_AACK && !oe_n_q) else $error("own address not acknowledged");
    foreign_idle_a: assert property (s_addr_end and (sh_q[7:1] != own_addr)
        |=> st_q == ST_SKIP && oe_n_q) else $error("foreign address not ignored");
    busy_nak_a: assert property (s_addr_end and busy |=> st_q != ST_AACK)
        else $error("address acknowledged while busy");
    sda_change_a: assert property ($changed(oe_n_q) |-> $past(scl_fall || start || stop))
        else $error("SDA moved while SCL high");
    read_first_a: assert property (st_q == ST_AACK && rw_q && scl_fall && !start && !stop
        |=> st_q == ST_RD && oe_n_q == $past(rd_byte[7])) else $error("read byte not started");
    halve_all_a: assert property (go_q && cmd == `DPOT_C_HALVE_ALL && rdone == 2'h0 && ch_mask != 2'h0
        |=> w_q[0] == ($past(w_q[0]) >> 1)) else $error("halve all wrong");
    inc_sat_a: assert property (go_q && cmd == `DPOT_C_INC_ALL && w_q[1] == `DPOT_FULL
        && rdone == 2'h0 |=> w_q[1] == `DPOT_FULL) else $error("increment not saturated");
    reserved_a: assert property (go_q && cmd >= `DPOT_C_RSV_LO && rdone == 2'h0
        |=> $stable(w_q)) else $error("reserved code changed a wiper");
    restore_a: assert property (rdone[0] |=> w_q[0] == $past(nv_wiper[0]))
        else $error("restore did not load wiper");

endmodule

// ==== dpot_i2c_slave_tb.sv ====
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module dpot_i2c_slave_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_mclk, i_rstn, ce, hi, lo, scl, m_sda, oe_n, sd_o, busy, k, ak;
    logic [7:0] w1, w2, dw, a, b, sv, wm [2];
    int         error_cnt, cmp_count, n;
    wire        sda = m_sda & (oe_n | sd_o);
    dpot_i2c_slave #(.P_SAVE_CYC(400), .P_RESTORE_CYC(200)) dpot_i2c_slave_inst (
        .i_mclk, .i_rstn, .i_ce(ce), .i_scl(scl), .i_sda(sda), .o_sda(sd_o), .o_sda_oe_n(oe_n),
        .i_address_select_pin_high(hi), .i_address_select_pin_low(lo),
        .o_first_wiper_channel(w1), .o_second_wiper_channel(w2), .o_busy(busy));
    dpot_host dpot_host_inst (.i_mclk, .i_sda(sda), .o_scl(scl), .o_sda(m_sda));
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic send(input int m, input logic [7:0] ad, ins, dat);
        dpot_host_inst.start;
        dpot_host_inst.xbyte(ad, 1'b1, a, ak);
        if (m > 1) dpot_host_inst.xbyte(ins, 1'b1, a, k);
        if (m > 1) `CHK({ak, k}, 2'b00)
        if (m > 2) dpot_host_inst.xbyte(dat, 1'b1, a, k);
        if (m > 2) `CHK(k, 1'b0)
        dpot_host_inst.stop;
    endtask
    // Address-only writes until the device answers again
    task automatic poll;
        `CHK(busy, 1'b1)
        n = 0;
        do begin
            send(1, dw, 8'h00, 8'h00);
            n++;
        end while (ak !== 1'b0 && n < 60);
        `CHK({ak, (n > 1)}, 2'b01)
        if (ak !== 1'b0) wrap_up;
    endtask
    // Current read of two bytes into a and b, the last one not acknowledged
    task automatic rd2;
        dpot_host_inst.start;
        dpot_host_inst.xbyte(dw | 8'h01, 1'b1, a, k);
        `CHK(k, 1'b0)
        dpot_host_inst.xbyte(8'hff, 1'b0, a, k);
        dpot_host_inst.xbyte(8'hff, 1'b1, b, k);
        dpot_host_inst.stop;
    endtask
    function automatic logic [7:0] nxt(input logic [3:0] cc, input logic [7:0] v);
        case (cc)
            4'h3, 4'h4: return v >> 1;
            4'h5, 4'h6: return (v == 8'h00) ? v : v - 8'h01;
            4'h8, 4'h9: return (v == 8'h00) ? 8'h01 : (v[7] ? 8'hff : v << 1);
            4'ha, 4'hb: return (v == 8'hff) ? v : v + 8'h01;
            default: return v;
        endcase
    endfunction
    task automatic cmd(input logic [3:0] cc, input logic [2:0] ch);
        logic al;
        if (cc inside {4'h1, 4'h2, 4'h7}) cc = 4'h0;
        al = cc inside {4'h4, 4'h6, 4'h9, 4'hb};
        send(2, dw, {1'b1, cc, ch}, 8'h00);
        if (ch == 3'h1 || (al && ch == 3'h3)) wm[0] = nxt(cc, wm[0]);
        if (ch == 3'h3 || (al && ch == 3'h1)) wm[1] = nxt(cc, wm[1]);
        `CHK({w1, w2}, {wm[0], wm[1]})
    endtask
    initial begin
        i_rstn = 1'b0;
        ce = 1'b0;
        void'($urandom(32'h95bb8a80));
        {hi, lo} = 2'($urandom);
        dw = {5'h0b, hi, lo, 1'b0};
        dpot_host_inst.q(8);
        i_rstn = 1'b1;
        `CHK({w1, w2, busy}, {8'h80, 8'h80, 1'b1})
        // Enable held low a while: a timer that ignored it would finish 20 cycles early
        dpot_host_inst.q(20);
        ce = 1'b1;
        for (n = 0; busy !== 1'b0 && n < 1000; n++) dpot_host_inst.q(1);
        `CHK({busy, (n inside {[190:210]})}, 2'b01)
        if (busy !== 1'b0) wrap_up;
        dpot_host_inst.q(10);
        send(1, dw ^ 8'h02, 8'h00, 8'h00);
        `CHK(ak, 1'b1)
        // Straps move while idle: the old address must go silent
        {hi, lo} = ~{hi, lo};
        dpot_host_inst.q(4);
        send(1, dw, 8'h00, 8'h00);
        `CHK(ak, 1'b1)
        dw = {5'h0b, hi, lo, 1'b0};
        wm = '{8'($urandom), 8'($urandom)};
        send(3, dw, 8'h01, wm[0]);
        send(3, dw, 8'h03, wm[1]);
        rd2;
        `CHK({w1, w2, a, b}, {wm[0], wm[1], wm[1], wm[0]})
        $display("power-up and wiper access test done");
        send(3, dw, 8'h01, 8'h00);
        send(3, dw, 8'h03, 8'hff);
        wm = '{8'h00, 8'hff};
        repeat (9) cmd(4'h8, 3'h1);
        `CHK(w1, 8'hff)
        repeat (8) cmd(4'h3, 3'h1);
        for (int i = 0; i < 48; i++) cmd((i < 16) ? 4'(i) : 4'($urandom),
            (i % 5 == 4) ? 3'($urandom) : {1'b0, 1'($urandom), 1'b1});
        $display("quick command test done");
        sv = wm[0];
        send(2, dw, 8'h91, 8'h00);
        poll;
        send(3, dw, 8'h01, ~sv);
        send(2, dw, 8'h89, 8'h00);
        poll;
        send(2, dw, 8'h81, 8'h00);
        `CHK(w1, sv)
        send(2, dw, 8'hb9, 8'h00);
        poll;
        `CHK({w1, w2}, {sv, 8'h80})
        send(3, dw, 8'h24, ~sv);
        poll;
        send(3, dw, 8'h3a, 8'hff);
        `CHK(busy, 1'b0)
        send(2, dw, 8'h24, 8'h00);
        rd2;
        `CHK({a, b}, {~sv, 8'h00})
        send(2, dw, 8'h3a, 8'h00);
        rd2;
        `CHK({a, b}, {8'h00, 8'h00})
        $display("store and restore test done");
        wrap_up;
    end
endmodule

// ==== dpot_map.svh ====
`ifndef DPOT_MAP_SVH
`define DPOT_MAP_SVH

`define DPOT_CLK_MHZ      40
`define DPOT_SAVE_MS      26
`define DPOT_RESTORE_US   300
`define DPOT_SAVE_CYC     (`DPOT_SAVE_MS * 1000 * `DPOT_CLK_MHZ)
`define DPOT_RESTORE_CYC  (`DPOT_RESTORE_US * `DPOT_CLK_MHZ)
`define DPOT_TIMER_W      21

`define DPOT_ADDR_FIXED   5'h0b
`define DPOT_MID          8'h80
`define DPOT_FULL         8'hff
`define DPOT_TOL_DEF      8'h00

`define DPOT_MODE_BIT     7
`define DPOT_EE_BIT       5
`define DPOT_CMD_HI       6
`define DPOT_CMD_LO       3
`define DPOT_CH_FIRST     3'h1
`define DPOT_CH_SECOND    3'h3
`define DPOT_LOC_FIRST    5'h01
`define DPOT_LOC_SECOND   5'h03
`define DPOT_LOC_RO(l)    ((l[4:3] == 2'h3) && l[1])

`define DPOT_C_RESTORE    4'h1
`define DPOT_C_SAVE       4'h2
`define DPOT_C_HALVE_ONE  4'h3
`define DPOT_C_HALVE_ALL  4'h4
`define DPOT_C_DEC_ONE    4'h5
`define DPOT_C_DEC_ALL    4'h6
`define DPOT_C_RESET      4'h7
`define DPOT_C_DBL_ONE    4'h8
`define DPOT_C_DBL_ALL    4'h9
`define DPOT_C_INC_ONE    4'ha
`define DPOT_C_INC_ALL    4'hb
`define DPOT_C_RSV_LO     4'hc

`endif

// ==== dpot_nvstore.sv ====
`include "dpot_map.svh"
module dpot_nvstore
    import dpot_pkg::*;
#(
    parameter int unsigned P_SAVE_CYC    = `DPOT_SAVE_CYC,
    parameter int unsigned P_RESTORE_CYC = `DPOT_RESTORE_CYC
) (
    // Clock, reset, enable
    input  logic            i_mclk,
    input  logic            i_rstn,
    input  logic            i_ce,
    // Requests
    input  dpot_nv_wr_t     i_wr,
    input  logic [1:0]      i_restore,
    input  logic [4:0]      i_rd_loc,
    // Results
    output logic [7:0]      o_rd_data,
    output logic [1:0][7:0] o_nv_wiper,
    output logic            o_busy,
    output logic [1:0]      o_restore_done
);
    localparam int TW = `DPOT_TIMER_W;
    localparam logic [TW-1:0] SAVE_N    = TW'(P_SAVE_CYC);
    localparam logic [TW-1:0] RESTORE_N = TW'(P_RESTORE_CYC);

    logic [7:0]    mem_q [32];
    logic [7:0]    mem_d [32];
    logic [TW-1:0] tmr_q, tmr_d;
    logic [1:0]    mask_q, mask_d;
    logic          busy_q, busy_d;
    logic [1:0]    done_q, done_d;
    logic          wr_ok;

    // Factory tolerance bytes never take a write
    assign wr_ok = i_wr.en && !busy_q && !`DPOT_LOC_RO(i_wr.addr);

    for (genvar g = 0; g < 32; g++) begin : g_mem
        localparam logic [4:0] LOC  = 5'(g);
        localparam logic [7:0] INIT = (LOC == `DPOT_LOC_FIRST || LOC == `DPOT_LOC_SECOND) ? `DPOT_MID :
                                      (`DPOT_LOC_RO(LOC) ? `DPOT_TOL_DEF : 8'h00);
        always_comb begin
            mem_d[g] = mem_q[g];
            if (wr_ok && i_wr.addr == LOC) begin
                mem_d[g] = i_wr.data;
            end
        end
        always_ff @(posedge i_mclk) begin
            if (!i_rstn) begin
                mem_q[g] <= INIT;
            end else if (i_ce) begin
                mem_q[g] <= mem_d[g];
            end
        end
    end

    // One timer serves save and restore; reset itself starts the power-up restore
    always_comb begin
        tmr_d  = tmr_q;
        mask_d = mask_q;
        busy_d = busy_q;
        done_d = 2'h0;
        if (busy_q) begin
            if (tmr_q <= TW'(1)) begin
                busy_d = 1'b0;
                done_d = mask_q;
                mask_d = 2'h0;
            end else begin
                tmr_d = tmr_q - TW'(1);
            end
        end else if (wr_ok) begin
            tmr_d  = SAVE_N;
            busy_d = 1'b1;
        end else if (i_restore != 2'h0) begin
            tmr_d  = RESTORE_N;
            mask_d = i_restore;
            busy_d = 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            tmr_q  <= RESTORE_N;
            mask_q <= 2'h3;
            busy_q <= 1'b1;
            done_q <= 2'h0;
        end else if (i_ce) begin
            tmr_q  <= tmr_d;
            mask_q <= mask_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign o_rd_data      = mem_q[i_rd_loc];
    assign o_nv_wiper[0]  = mem_q[`DPOT_LOC_FIRST];
    assign o_nv_wiper[1]  = mem_q[`DPOT_LOC_SECOND];
    assign o_busy         = busy_q;
    assign o_restore_done = done_q;

endmodule

// ==== dpot_pkg.sv ====
package dpot_pkg;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_AACK, ST_INSTR, ST_IACK,
        ST_DATA, ST_DACK, ST_RD, ST_MACK, ST_SKIP
    } dpot_state_t;

    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [7:0] data;
    } dpot_nv_wr_t;

endpackage
